// ### dv/acd_amp_ctrl_props.sv
module acd_amp_ctrl_props #(
  parameter int RECHECK_CYCLES = 20,
  parameter int CYCLE_CYCLES = 50
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // Serial bus pins.
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // Instruction byte outputs.
  input wire logic diag_enable,
  input wire logic front_unmute,
  input wire logic fast_mute,
  input wire logic amp_on,
  input wire logic line_driver_diag
);
  timeunit 1ns;
  timeprecision 100ps;

  // The device acknowledges within two clocks of a register update.
  sequence ack_drive_s;
    ##[0:2] !sda_oe_n;
  endsequence

  // A change of diag_enable or front_unmute, two of the configuration outputs.
  sequence cfg_change_s;
    $changed({diag_enable, front_unmute});
  endsequence

  // Pin checks and update timing.
  reset_idle_a: assert property (@(posedge core_clk) !rstn |-> sda_oe_n && !amp_on && !diag_enable)
    else $error("outputs not idle in reset");
  sda_drive_a: assert property (@(posedge core_clk) disable iff (!rstn) sda_out == 1'b0)
    else $error("data pin drive value not low");
  sda_edge_a: assert property (@(posedge core_clk) disable iff (!rstn) $changed(sda_oe_n) |-> !$past(scl_in, 2))
    else $error("data line moved while clock high");
  ack_hold_a: assert property (@(posedge core_clk) disable iff (!rstn) $fell(sda_oe_n) |-> (!sda_oe_n) [*6])
    else $error("data line pull too short");
  rel_hold_a: assert property (@(posedge core_clk) disable iff (!rstn) $rose(sda_oe_n) |-> sda_oe_n [*6])
    else $error("data line release too short");
  oe_pulse_a: assert property (@(posedge core_clk) disable iff (!rstn) $fell(sda_oe_n) |-> ##[1:80] sda_oe_n)
    else $error("data line held low too long");
  cfg_ack_a: assert property (@(posedge core_clk) disable iff (!rstn) cfg_change_s |-> ack_drive_s)
    else $error("configuration changed without acknowledge");
  ctl_ack_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $changed({fast_mute, amp_on, line_driver_diag}) |-> ack_drive_s)
    else $error("control changed without acknowledge");
  cfg_ctl_apart_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $changed(diag_enable) |-> $stable({fast_mute, amp_on, line_driver_diag}))
    else $error("both bytes updated at one acknowledge");
endmodule // acd_amp_ctrl_props

bind acd_amp_ctrl acd_amp_ctrl_props #(.RECHECK_CYCLES(RECHECK_CYCLES), .CYCLE_CYCLES(CYCLE_CYCLES)) props_inst (
  .core_clk(core_clk), .rstn(rstn), .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .diag_enable(diag_enable), .front_unmute(front_unmute), .fast_mute(fast_mute), .amp_on(amp_on),
  .line_driver_diag(line_driver_diag)
);

// ### dv/acd_bus_master.sv
module acd_bus_master (
  // Bus lines.
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus: clock stands high, data released to the pull-up.
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // One 32 ns bit: data moves mid-low, is sampled late in the high phase.
  task automatic bit_io(input logic b, output logic r);
    #12 sda_pull = ~b;
    #4 scl = 1'b1;
    #15 r = sda;
    #1 scl = 1'b0;
  endtask

  // Start: data falls while the clock is high.
  task automatic start_cond();
    #16 sda_pull = 1'b1;
    #16 scl = 1'b0;
  endtask

  // Stop: data rises while the clock is high, then the clock stands still.
  task automatic stop_cond();
    #12 sda_pull = 1'b1;
    #4 scl = 1'b1;
    #16 sda_pull = 1'b0;
    #16;
  endtask

  // Sends a byte MSB first and returns the acknowledge level seen.
  task automatic wr_byte(input logic [7:0] d, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, ack_n);
  endtask

  // Receives a byte and acknowledges it unless it is the last.
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule // acd_bus_master

// ### dv/tb_acd_amp_ctrl.sv
module tb_acd_amp_ctrl;
  timeunit 1ns;
  timeprecision 100ps;

  logic core_clk, rstn, scl, sda_pull, sda, sda_out, sda_oe_n, thermal_warn;
  logic [3:0] short_gnd_src, short_gnd_sink, short_vs, short_load, offset_high, prot_active;
  logic diag_enable, offset_enable, front_gain_16db, rear_gain_16db, front_unmute, rear_unmute, clip_thr_10pct;
  logic fast_mute, amp_on, line_driver_diag;
  int fail_count, n_compared;

  // Open drain data wire with pull-up.
  assign sda = !(sda_pull || (!sda_oe_n && !sda_out));

  acd_amp_ctrl #(.RECHECK_CYCLES(20), .CYCLE_CYCLES(50)) acd_amp_ctrl_inst (
    .core_clk(core_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .short_gnd_src(short_gnd_src), .short_gnd_sink(short_gnd_sink), .short_vs(short_vs),
    .short_load(short_load), .offset_high(offset_high), .prot_active(prot_active), .thermal_warn(thermal_warn),
    .diag_enable(diag_enable), .offset_enable(offset_enable), .front_gain_16db(front_gain_16db),
    .rear_gain_16db(rear_gain_16db), .front_unmute(front_unmute), .rear_unmute(rear_unmute),
    .clip_thr_10pct(clip_thr_10pct), .fast_mute(fast_mute), .amp_on(amp_on), .line_driver_diag(line_driver_diag)
  );

  acd_bus_master acd_bus_master_inst (.scl(scl), .sda_pull(sda_pull), .sda(sda));

  // Clock of 4 ns.
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Compares one value and counts the result.
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic finish_test();
    if (fail_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Writes n bytes, the first being the address, and returns the acknowledge levels.
  task automatic bus_write(input logic [31:0] bytes, input int n, output logic [3:0] ack_n);
    logic a;
    ack_n = 4'hf;
    // Start off the clock edge so that the pins never move on a sampling edge.
    @(posedge core_clk);
    #1;
    acd_bus_master_inst.start_cond();
    for (int i = 0; i < n; i++) begin
      acd_bus_master_inst.wr_byte(bytes[31-8*i -: 8], a);
      ack_n[3-i] = a;
    end
    acd_bus_master_inst.stop_cond();
  endtask

  // Reads the four status bytes and compares them in order.
  task automatic bus_read(input logic [31:0] exp);
    logic a;
    logic [7:0] d;
    @(posedge core_clk);
    #1;
    acd_bus_master_inst.start_cond();
    acd_bus_master_inst.wr_byte(8'hd9, a);
    check("read address ack", {7'h0, a}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      acd_bus_master_inst.rd_byte(i == 3, d);
      check("status byte", d, exp[31-8*i -: 8]);
    end
    acd_bus_master_inst.stop_cond();
  endtask

  // Bound on the whole run.
  initial begin
    #100us;
    fail_count++;
    finish_test();
  end

  // Main sequence.
  initial begin
    logic [3:0] ack;
    logic [7:0] cfg, ctl, outs;
    fail_count = 0;
    n_compared = 0;
    rstn = 1'b1;
    {short_gnd_src, short_gnd_sink, short_vs, short_load, offset_high, prot_active, thermal_warn} = 25'h0;
    // A clean falling edge makes sure the asynchronous reset is seen before the first clock.
    #1 rstn = 1'b0;
    repeat (16) @(posedge core_clk);
    #1 rstn = 1'b1;
    repeat (8) @(posedge core_clk);
    outs = {diag_enable, offset_enable, front_unmute, rear_unmute, fast_mute, amp_on, line_driver_diag, sda_oe_n};
    check("reset outputs", outs, 8'h01);
    for (int k = 0; k < 2; k++) begin
      cfg = k ? 8'h2a : 8'hd5;
      ctl = k ? 8'h90 : 8'h28;
      bus_write({8'hd8, cfg, ctl, 8'h00}, 3, ack);
      check("write acks", {4'h0, ack}, 8'h01);
      outs = {1'b0, diag_enable, offset_enable, front_gain_16db, rear_gain_16db, front_unmute, rear_unmute,
              clip_thr_10pct};
      check("config outputs", outs, {1'b0, cfg[6:0]});
      check("control outputs", {5'h0, fast_mute, amp_on, line_driver_diag}, {5'h0, ctl[5:3]});
    end
    bus_write({8'hda, 8'h7f, 8'h38, 8'h00}, 2, ack);
    check("foreign address acks", {4'h0, ack}, 8'h0f);
    check("outputs kept", {7'h0, diag_enable}, 8'h00);
    @(posedge core_clk);
    #1 short_gnd_src = 4'h1;
    short_vs = 4'h5;
    short_load = 4'he;
    short_gnd_sink = 4'h8;
    thermal_warn = 1'b1;
    bus_write({8'hd8, 8'h40, 8'h10, 8'h55}, 4, ack);
    check("extra byte refused", {4'h0, ack}, 8'h01);
    bus_read(32'h8000c000);
    bus_read(32'h8308c201);
    @(posedge core_clk);
    #1 {short_gnd_src, short_gnd_sink, short_vs, short_load, thermal_warn} = 17'h0;
    bus_read(32'h0000c000);
    @(posedge core_clk);
    #1 offset_high = 4'h3;
    bus_write({8'hd8, 8'h60, 8'h10, 8'h00}, 3, ack);
    check("offset write acks", {4'h0, ack}, 8'h01);
    repeat (50) @(posedge core_clk);
    #1 offset_high = 4'h1;
    bus_read(32'h0480c000);
    @(posedge core_clk);
    #1 prot_active = 4'h4;
    repeat (100) @(posedge core_clk);
    bus_read(32'h4080c000);
    // A reset in mid-run clears both instruction bytes and the stored results.
    @(posedge core_clk);
    #1 rstn = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 rstn = 1'b1;
    repeat (8) @(posedge core_clk);
    outs = {diag_enable, offset_enable, front_unmute, rear_unmute, fast_mute, amp_on, line_driver_diag, sda_oe_n};
    check("mid-run reset outputs", outs, 8'h01);
    bus_read(32'h00000000);
    finish_test();
  end
endmodule // tb_acd_amp_ctrl

// ### verilog/acd_amp_ctrl.sv
module acd_amp_ctrl #(
  parameter int RECHECK_CYCLES = acd_pkg::RECHECK_CYC,
  parameter int CYCLE_CYCLES = acd_pkg::CYCLE_CYC
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // Serial bus pins, open drain data.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Fault sensors, one bit per channel in bus order; thermal_warn is a single bit for the device.
  input wire logic [3:0] short_gnd_src,
  input wire logic [3:0] short_gnd_sink,
  input wire logic [3:0] short_vs,
  input wire logic [3:0] short_load,
  input wire logic [3:0] offset_high,
  input wire logic [3:0] prot_active,
  input wire logic thermal_warn,
  // Amplifier controls.
  output logic diag_enable,
  output logic offset_enable,
  output logic front_gain_16db,
  output logic rear_gain_16db,
  output logic front_unmute,
  output logic rear_unmute,
  output logic clip_thr_10pct,
  output logic fast_mute,
  output logic amp_on,
  output logic line_driver_diag
);

  acd_diag_if dif();

  logic [1:0] scl_sync, sda_sync;
  logic scl_d, sda_d;
  logic [24:0] flt_sync1, flt_sync2;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  acd_pkg::acd_bus_state_t state, next_state;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] rx_sh, next_rx_sh;
  logic [7:0] tx_sh, next_tx_sh;
  logic [1:0] byte_idx, next_byte_idx;
  logic rw, next_rw;
  logic next_sda_oe_n;
  logic [7:0] amp_config_byte, next_amp_config_byte;
  logic [7:0] operating_control_byte, next_operating_control_byte;
  logic next_read_done, next_offset_arm;
  logic [7:0] left_front_status_byte, left_rear_status_byte;
  logic [7:0] right_front_status_byte, right_rear_status_byte;
  logic [7:0] tx_byte;
  logic [1:0] tx_idx;

  // Pin synchronisers; the first stage feeds only the second.
  // Resetting to the idle-high level keeps a false edge away after reset.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      flt_sync1 <= '0;
      flt_sync2 <= '0;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
      flt_sync1 <= {thermal_warn, prot_active, offset_high, short_load, short_vs, short_gnd_sink, short_gnd_src};
      flt_sync2 <= flt_sync1;
    end
  end

  // Bus events seen on the synchronised lines.
  assign scl_rise = scl_sync[1] & ~scl_d;
  assign scl_fall = ~scl_sync[1] & scl_d;
  assign bus_start = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  assign bus_stop = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

  // Sensor bits and control bits handed to the diagnostic sequencer.
  assign dif.flt_gnd_src = flt_sync2[3:0];
  assign dif.flt_gnd_sink = flt_sync2[7:4];
  assign dif.flt_vs = flt_sync2[11:8];
  assign dif.flt_load = flt_sync2[15:12];
  assign dif.flt_offset = flt_sync2[19:16];
  assign dif.prot = flt_sync2[23:20];
  assign dif.diag_en = amp_config_byte[acd_pkg::CFG_DIAG_EN];
  assign dif.offset_en = amp_config_byte[acd_pkg::CFG_OFFSET_EN];

  // Status bytes as read out; all four share the fault bit layout, while bits 7 and 6 carry per-byte flags, both zero in the right rear byte.
  assign left_front_status_byte = acd_pkg::acd_status_byte(flt_sync2[24], dif.rep_done,
    dif.rep_load[acd_pkg::CH_LF], dif.rep_off[acd_pkg::CH_LF],
    dif.rep_vs[acd_pkg::CH_LF], dif.rep_gnd[acd_pkg::CH_LF]);
  assign left_rear_status_byte = acd_pkg::acd_status_byte(dif.offset_en, 1'b0,
    dif.rep_load[acd_pkg::CH_LR], dif.rep_off[acd_pkg::CH_LR],
    dif.rep_vs[acd_pkg::CH_LR], dif.rep_gnd[acd_pkg::CH_LR]);
  assign right_front_status_byte = acd_pkg::acd_status_byte(amp_on, dif.diag_en,
    dif.rep_load[acd_pkg::CH_RF], dif.rep_off[acd_pkg::CH_RF],
    dif.rep_vs[acd_pkg::CH_RF], dif.rep_gnd[acd_pkg::CH_RF]);
  assign right_rear_status_byte = acd_pkg::acd_status_byte(1'b0, 1'b0,
    dif.rep_load[acd_pkg::CH_RR], dif.rep_off[acd_pkg::CH_RR],
    dif.rep_vs[acd_pkg::CH_RR], dif.rep_gnd[acd_pkg::CH_RR]);

  // Index of the byte to send next: the first after the address, then the following one, wrapping after the last.
  assign tx_idx = (state == acd_pkg::BS_MACK) && (byte_idx != acd_pkg::LAST_RD_BYTE) ? byte_idx + 1'b1 : 2'h0;

  // Byte chosen for transmission, in fixed channel order.
  always_comb begin
    case (tx_idx)
      2'h0: tx_byte = left_front_status_byte;
      2'h1: tx_byte = left_rear_status_byte;
      2'h2: tx_byte = right_front_status_byte;
      default: tx_byte = right_rear_status_byte;
    endcase
  end

  // Bus slave: address match, byte shifting, acknowledge and register writes.
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_rx_sh = rx_sh;
    next_tx_sh = tx_sh;
    next_byte_idx = byte_idx;
    next_rw = rw;
    next_sda_oe_n = sda_oe_n;
    next_amp_config_byte = amp_config_byte;
    next_operating_control_byte = operating_control_byte;
    next_read_done = 1'b0;
    next_offset_arm = 1'b0;
    case (state)
      acd_pkg::BS_IDLE: next_sda_oe_n = 1'b1;
      acd_pkg::BS_ADDR, acd_pkg::BS_RX: begin
        if (scl_rise) begin
          next_rx_sh = {rx_sh[6:0], sda_sync[1]};
          next_bit_cnt = bit_cnt + 1'b1;
        end else if (scl_fall && bit_cnt == 4'h8) begin
          next_bit_cnt = 4'h0;
          if (state == acd_pkg::BS_ADDR) begin
            if (rx_sh[7:1] == acd_pkg::DEV_ADDR) begin
              next_rw = rx_sh[0];
              next_read_done = rx_sh[0];
              next_sda_oe_n = 1'b0;
              next_state = acd_pkg::BS_ACK_ADDR;
            end else begin
              next_state = acd_pkg::BS_IDLE;
            end
          end else if ({1'b0, byte_idx} < acd_pkg::NUM_WR_BYTES) begin
            if (byte_idx == 2'h0) begin
              next_amp_config_byte = rx_sh;
              next_offset_arm = rx_sh[acd_pkg::CFG_OFFSET_EN];
            end else begin
              next_operating_control_byte = rx_sh;
            end
            next_sda_oe_n = 1'b0;
            next_state = acd_pkg::BS_ACK_RX;
          end else begin
            next_state = acd_pkg::BS_IDLE;
          end
        end
      end
      acd_pkg::BS_ACK_ADDR: begin
        if (scl_fall) begin
          next_byte_idx = 2'h0;
          if (rw) begin
            next_tx_sh = tx_byte;
            next_sda_oe_n = tx_byte[7];
            next_state = acd_pkg::BS_TX;
          end else begin
            next_sda_oe_n = 1'b1;
            next_state = acd_pkg::BS_RX;
          end
        end
      end
      acd_pkg::BS_ACK_RX: begin
        if (scl_fall) begin
          next_sda_oe_n = 1'b1;
          next_byte_idx = byte_idx + 1'b1;
          next_state = acd_pkg::BS_RX;
        end
      end
      acd_pkg::BS_TX: begin
        if (scl_fall) begin
          if (bit_cnt == 4'h7) begin
            next_bit_cnt = 4'h0;
            next_sda_oe_n = 1'b1;
            next_state = acd_pkg::BS_MACK;
          end else begin
            next_bit_cnt = bit_cnt + 1'b1;
            next_tx_sh = {tx_sh[6:0], 1'b0};
            next_sda_oe_n = tx_sh[6];
          end
        end
      end
      acd_pkg::BS_MACK: begin
        if (scl_rise) begin
          // The master acknowledges low to ask for another byte.
          next_rw = ~sda_sync[1];
        end else if (scl_fall) begin
          if (rw) begin
            next_byte_idx = tx_idx;
            next_tx_sh = tx_byte;
            next_sda_oe_n = tx_byte[7];
            next_state = acd_pkg::BS_TX;
          end else begin
            next_state = acd_pkg::BS_IDLE;
          end
        end
      end
      default: next_state = acd_pkg::BS_IDLE;
    endcase
    // Start and stop take over from any state.
    // A start in mid-byte drops the byte in flight and listens for an address.
    if (bus_start) begin
      next_state = acd_pkg::BS_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_oe_n = 1'b1;
    end else if (bus_stop) begin
      next_state = acd_pkg::BS_IDLE;
      next_sda_oe_n = 1'b1;
    end
  end

  // Bus slave registers.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= acd_pkg::BS_IDLE;
      bit_cnt <= 4'h0;
      rx_sh <= 8'h00;
      tx_sh <= 8'h00;
      byte_idx <= 2'h0;
      rw <= 1'b0;
      sda_oe_n <= 1'b1;
      amp_config_byte <= acd_pkg::CFG_RESET;
      operating_control_byte <= acd_pkg::CTL_RESET;
      dif.read_done <= 1'b0;
      dif.offset_arm <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      rx_sh <= next_rx_sh;
      tx_sh <= next_tx_sh;
      byte_idx <= next_byte_idx;
      rw <= next_rw;
      sda_oe_n <= next_sda_oe_n;
      amp_config_byte <= next_amp_config_byte;
      operating_control_byte <= next_operating_control_byte;
      dif.read_done <= next_read_done;
      dif.offset_arm <= next_offset_arm;
    end
  end

  // The data pin only ever pulls low.
  assign sda_out = 1'b0;

  // Amplifier controls straight from the instruction bytes.
  assign diag_enable = amp_config_byte[acd_pkg::CFG_DIAG_EN];
  assign offset_enable = amp_config_byte[acd_pkg::CFG_OFFSET_EN];
  assign front_gain_16db = amp_config_byte[acd_pkg::CFG_FRONT_GAIN];
  assign rear_gain_16db = amp_config_byte[acd_pkg::CFG_REAR_GAIN];
  assign front_unmute = amp_config_byte[acd_pkg::CFG_FRONT_UNMUTE];
  assign rear_unmute = amp_config_byte[acd_pkg::CFG_REAR_UNMUTE];
  assign clip_thr_10pct = amp_config_byte[acd_pkg::CFG_CLIP_THR];
  assign fast_mute = operating_control_byte[acd_pkg::CTL_FAST_MUTE];
  assign amp_on = operating_control_byte[acd_pkg::CTL_AMP_ON];
  assign line_driver_diag = operating_control_byte[acd_pkg::CTL_LINE_DIAG];

  // Diagnostic windows and result storage.
  acd_diag_seq #(
    .RECHECK_CYCLES(RECHECK_CYCLES),
    .CYCLE_CYCLES(CYCLE_CYCLES)
  ) u_diag (
    .core_clk(core_clk),
    .rstn(rstn),
    .dif(dif.seq)
  );

endmodule // acd_amp_ctrl

// ### verilog/acd_diag_if.sv
interface acd_diag_if;
  logic read_done;
  logic offset_arm;
  logic diag_en;
  logic offset_en;
  logic [3:0] flt_gnd_src;
  logic [3:0] flt_gnd_sink;
  logic [3:0] flt_vs;
  logic [3:0] flt_load;
  logic [3:0] flt_offset;
  logic [3:0] prot;
  logic [3:0] rep_gnd;
  logic [3:0] rep_vs;
  logic [3:0] rep_load;
  logic [3:0] rep_off;
  logic rep_done;

  modport bus (
    output read_done, offset_arm, diag_en, offset_en, flt_gnd_src, flt_gnd_sink, flt_vs, flt_load,
    flt_offset, prot,
    input rep_gnd, rep_vs, rep_load, rep_off, rep_done
  );
  modport seq (
    input read_done, offset_arm, diag_en, offset_en, flt_gnd_src, flt_gnd_sink, flt_vs, flt_load,
    flt_offset, prot,
    output rep_gnd, rep_vs, rep_load, rep_off, rep_done
  );
endinterface

// ### verilog/acd_diag_seq.sv
module acd_diag_seq #(
  parameter int RECHECK_CYCLES = acd_pkg::RECHECK_CYC,
  parameter int CYCLE_CYCLES = acd_pkg::CYCLE_CYC
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // Link to the bus side.
  acd_diag_if.seq dif
);

  acd_pkg::acd_diag_state_t state, next_state;
  logic [acd_pkg::CNT_W-1:0] cnt, next_cnt;
  logic [3:0] acc_gs, acc_gk, acc_vs, acc_ld, acc_off;
  logic [3:0] next_acc_gs, next_acc_gk, next_acc_vs, next_acc_ld, next_acc_off;
  logic off_blk, next_off_blk;
  logic [3:0] next_rep_gnd, next_rep_vs, next_rep_load, next_rep_off;
  logic next_rep_done;
  logic overload;
  logic cycle_end;

  assign overload = |dif.prot;
  assign cycle_end = (state == acd_pkg::DS_CYCLE) && (cnt == acd_pkg::CNT_W'(CYCLE_CYCLES - 1));

  // Measurement windows, overload recheck and the diagnostic cycle.
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_rep_gnd = dif.rep_gnd;
    next_rep_vs = dif.rep_vs;
    next_rep_load = dif.rep_load;
    next_rep_off = dif.rep_off;
    next_rep_done = dif.rep_done;
    // Faults count only when stable over the whole period.
    next_acc_gs = acc_gs & dif.flt_gnd_src & {4{dif.diag_en}};
    next_acc_gk = acc_gk & dif.flt_gnd_sink & {4{dif.diag_en}};
    next_acc_vs = acc_vs & dif.flt_vs & {4{dif.diag_en}};
    next_acc_ld = acc_ld & dif.flt_load & {4{dif.diag_en}};
    next_acc_off = acc_off & dif.flt_offset;
    next_off_blk = off_blk | overload;
    case (state)
      acd_pkg::DS_IDLE: begin
        next_cnt = '0;
        if (dif.diag_en && overload) begin
          next_state = acd_pkg::DS_CHECK;
        end
      end
      acd_pkg::DS_CHECK: begin
        next_cnt = cnt + 1'b1;
        if (cnt == acd_pkg::CNT_W'(RECHECK_CYCLES - 1)) begin
          next_cnt = '0;
          next_state = overload ? acd_pkg::DS_CYCLE : acd_pkg::DS_IDLE;
        end
      end
      acd_pkg::DS_CYCLE: begin
        next_cnt = cnt + 1'b1;
        if (cycle_end) begin
          next_state = acd_pkg::DS_DONE;
        end
      end
      acd_pkg::DS_DONE: next_cnt = '0;
      default: next_state = acd_pkg::DS_IDLE;
    endcase
    if (!dif.diag_en) begin
      next_state = acd_pkg::DS_IDLE;
    end
    // A read reports the period just closed and restarts every window.
    if (dif.read_done) begin
      next_rep_vs = acc_vs;
      next_rep_gnd = acc_gs | (acc_gk & ~acc_vs);
      next_rep_load = acc_ld & ~acc_vs & ~acc_gs & ~acc_gk;
      next_rep_off = acc_off & {4{~off_blk & dif.offset_en}};
      next_rep_done = (state == acd_pkg::DS_DONE) || cycle_end;
      next_acc_gs = {4{dif.diag_en}};
      next_acc_gk = {4{dif.diag_en}};
      next_acc_vs = {4{dif.diag_en}};
      next_acc_ld = {4{dif.diag_en}};
      next_acc_off = 4'hf;
      // An overload in the restart cycle still blocks the new window.
      next_off_blk = overload;
      if (!cycle_end) begin
        next_state = acd_pkg::DS_IDLE;
        next_cnt = '0;
      end
    end
    // Writing the offset enable to one opens a fresh offset window.
    if (dif.offset_arm) begin
      next_acc_off = 4'hf;
      next_off_blk = overload;
    end
  end

  // State registers.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= acd_pkg::DS_IDLE;
      cnt <= '0;
      acc_gs <= '0;
      acc_gk <= '0;
      acc_vs <= '0;
      acc_ld <= '0;
      acc_off <= '0;
      off_blk <= 1'b0;
      dif.rep_gnd <= '0;
      dif.rep_vs <= '0;
      dif.rep_load <= '0;
      dif.rep_off <= '0;
      dif.rep_done <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      acc_gs <= next_acc_gs;
      acc_gk <= next_acc_gk;
      acc_vs <= next_acc_vs;
      acc_ld <= next_acc_ld;
      acc_off <= next_acc_off;
      off_blk <= next_off_blk;
      dif.rep_gnd <= next_rep_gnd;
      dif.rep_vs <= next_rep_vs;
      dif.rep_load <= next_rep_load;
      dif.rep_off <= next_rep_off;
      dif.rep_done <= next_rep_done;
    end
  end

endmodule // acd_diag_seq

// ### verilog/acd_pkg.sv
package acd_pkg;

  // Bus address: the upper seven bits of the address byte.
  localparam logic [6:0] DEV_ADDR = 7'h6c;
  localparam logic [2:0] NUM_WR_BYTES = 3'h2;
  localparam logic [1:0] LAST_RD_BYTE = 2'h3;

  // Field positions in the amplifier configuration byte.
  localparam int CFG_DIAG_EN = 6;
  localparam int CFG_OFFSET_EN = 5;
  localparam int CFG_FRONT_GAIN = 4;
  localparam int CFG_REAR_GAIN = 3;
  localparam int CFG_FRONT_UNMUTE = 2;
  localparam int CFG_REAR_UNMUTE = 1;
  localparam int CFG_CLIP_THR = 0;

  // Field positions in the operating control byte.
  localparam int CTL_FAST_MUTE = 5;
  localparam int CTL_AMP_ON = 4;
  localparam int CTL_LINE_DIAG = 3;

  // Field positions in the status bytes.
  localparam int ST_HI7 = 7;
  localparam int ST_HI6 = 6;
  localparam int FLT_LOAD = 3;
  localparam int FLT_OFFSET = 2;
  localparam int FLT_VS = 1;
  localparam int FLT_GND = 0;

  // Channel order on the bus.
  localparam int CH_LF = 0;
  localparam int CH_LR = 1;
  localparam int CH_RF = 2;
  localparam int CH_RR = 3;

  // Values after reset: standby, muted, diagnostics off.
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // Diagnostic timing.
  localparam int CLK_KHZ = 250000;
  localparam int T_RECHECK_MS = 1;
  localparam int T_CYCLE_MS = 100;
  localparam int RECHECK_CYC = T_RECHECK_MS * CLK_KHZ;
  localparam int CYCLE_CYC = T_CYCLE_MS * CLK_KHZ;
  localparam int CNT_W = 25;

  typedef enum logic [6:0] {
    BS_IDLE = 7'h01,
    BS_ADDR = 7'h02,
    BS_ACK_ADDR = 7'h04,
    BS_RX = 7'h08,
    BS_ACK_RX = 7'h10,
    BS_TX = 7'h20,
    BS_MACK = 7'h40
  } acd_bus_state_t;

  typedef enum logic [3:0] {
    DS_IDLE = 4'h1,
    DS_CHECK = 4'h2,
    DS_CYCLE = 4'h4,
    DS_DONE = 4'h8
  } acd_diag_state_t;

  // Assembles one status byte from two flag bits and a channel's faults.
  function automatic logic [7:0] acd_status_byte(input logic hi7, input logic hi6, input logic load,
                                                 input logic off, input logic vs, input logic gnd);
    acd_status_byte = {hi7, hi6, 2'h0, load, off, vs, gnd};
  endfunction

endpackage
